// [src/lslc_pkg.sv]
`default_nettype none
package lslc_pkg;

  // ----------------------------------------------------------------
  // Chain and latch geometry
  // ----------------------------------------------------------------
  localparam int CHAIN_W = 49;
  localparam int LATCH_W = 48;
  localparam int STORE_W = 40;
  localparam int SELECT_BIT = 48;
  localparam int CMD_HI = 47;
  localparam int CMD_LO = 40;
  localparam logic [7:0] WRITE_CMD = 8'h96;

  // ----------------------------------------------------------------
  // Function-side field layout, in chain bit numbers
  // ----------------------------------------------------------------
  localparam int FUNC_HI = 39;
  localparam int FUNC_LO = 3;
  localparam int PEAK_HI = 2;
  localparam int PEAK_LO = 0;
  localparam int RED_HI = 9;
  localparam int RED_LO = 3;
  localparam int GREEN_HI = 16;
  localparam int GREEN_LO = 10;
  localparam int BLUE_HI = 23;
  localparam int BLUE_LO = 17;
  localparam int BRIGHT_W = 7;
  localparam int PEAK_W = 3;
  localparam int SELECTOR_W = 2;
  localparam int DEFAULT_SELECTOR_POS = 26;

  // ----------------------------------------------------------------
  // Reset values and brightness scale
  // ----------------------------------------------------------------
  localparam logic [PEAK_W-1:0] PEAK_RESET = 3'h0;
  localparam logic [LATCH_W-1:0] ENABLE_RESET = 48'h0;
  localparam logic [STORE_W-1:0] STORE_RESET = 40'h0;
  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 49'h0;
  localparam int RATIO_W = 10;
  localparam int RATIO_MIN_PERMILLE = 60;
  localparam int RATIO_SPAN_PERMILLE = 940;
  localparam int BRIGHT_MAX = 127;

  // ----------------------------------------------------------------
  // Power-save selector codes
  // ----------------------------------------------------------------
  localparam logic [SELECTOR_W-1:0] SEL_ALWAYS_ON = 2'h0;
  localparam logic [SELECTOR_W-1:0] SEL_SCLK_WAKE = 2'h1;
  localparam logic [SELECTOR_W-1:0] SEL_DATA_WAKE = 2'h2;
  localparam logic [SELECTOR_W-1:0] SEL_ALWAYS_SAVE = 2'h3;

  typedef enum logic [0:0] {
    LSLC_NORMAL,
    LSLC_SAVE
  } lslc_power_type;

endpackage
`default_nettype wire

// [src/lslc_shift_chain.sv]
`timescale 1ns/1ps
`default_nettype none
module lslc_shift_chain
  import lslc_pkg::*;
(
  // Link clock and reset
  input wire logic shift_clk,
  input wire logic arst_n,
  // Serial data
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Towards the system domain
  output logic [CHAIN_W-1:0] chain,
  output logic shift_toggle
);

  typedef struct packed {
    logic [CHAIN_W-1:0] chain;
    logic toggle;
  } lslc_link_state_type;

  lslc_link_state_type state;
  lslc_link_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.chain = {state.chain[CHAIN_W-2:0], serial_data_in}; // see [R18]
    next_state.toggle = ~state.toggle; // see [R9]
  end

  always_ff @(posedge shift_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{chain: CHAIN_RESET, toggle: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign serial_data_out = state.chain[SELECT_BIT]; // see [R18]
  assign chain = state.chain;
  assign shift_toggle = state.toggle;

endmodule // lslc_shift_chain
`default_nettype wire

// [src/lslc_top.sv]
// Functional notes
// [R1] Each colour group scales its current in 128 steps, 6% to 100%.
// [R2] A new group brightness code takes effect immediately.
// [R3] Blanking low: each sink follows its on/off latch bit.
// [R4] Blanking high: every sink forced off.
// [R5] On/off latch clears to zero at power-up.
// [R6] Power save stops outputs and fault detectors; logic keeps working.
// [R7] Selector 00 always normal, 11 always power save.
// [R8] Selector 01 or 10: all-zero on/off write enters power save.
// [R9] Selector 01: any shift clock rising edge leaves power save.
// [R10] Selector 10: nonzero on/off latch leaves power save.
// [R11] After leaving power save, sinks follow latch and blanking again.
// [R12] Controller holds blanking high until outputs settle after wake.
// [R13] 49-bit chain, 48-bit on/off latch, 40-bit store plus command.
// [R14] Strobe with top bit zero loads lower 48 bits to on/off latch.
// [R15] Top bit one and command 96h load bits 39:3 into store.
// [R16] Peak current code changes only after two identical qualifying writes.
// [R17] Function load pulse only on strobe rise with top bit one.
// [R18] Shift clock shifts serial input into bit zero toward top bit.
// [R19] Peak code bits 2:0; red 9:3, green 16:10, blue 23:17.
// [R20] Peak current code resets to zero.
// [R21] Top bit one with wrong command leaves every latch unchanged.
// [R22] Selector bit position within the store is a design parameter.
`timescale 1ns/1ps
`default_nettype none
module lslc_top
  import lslc_pkg::*;
#(
  parameter int SELECTOR_POS = DEFAULT_SELECTOR_POS // see [R22]
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Serial link from the display controller
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  input wire logic LATCH_STROBE,
  input wire logic BLANKING,
  // Sink output enables
  output logic [LATCH_W-1:0] SINK_OUTPUT,
  // Current control
  output logic [PEAK_W-1:0] PEAK_CURRENT_CODE,
  output logic [BRIGHT_W-1:0] RED_BRIGHTNESS_CODE,
  output logic [BRIGHT_W-1:0] GREEN_BRIGHTNESS_CODE,
  output logic [BRIGHT_W-1:0] BLUE_BRIGHTNESS_CODE,
  output logic [RATIO_W-1:0] RED_RATIO_PERMILLE,
  output logic [RATIO_W-1:0] GREEN_RATIO_PERMILLE,
  output logic [RATIO_W-1:0] BLUE_RATIO_PERMILLE,
  // Power state
  output logic POWER_SAVE_STATE,
  output logic ANALOG_ENABLE,
  output logic FAULT_DETECT_ENABLE,
  output logic [SELECTOR_W-1:0] POWER_SAVE_SELECTOR
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // Both selector bits must fall inside the stored part of the chain word.
  if (SELECTOR_POS < FUNC_LO || SELECTOR_POS + SELECTOR_W - 1 > FUNC_HI) begin : g_bad_selector_pos
    $error("SELECTOR_POS must place both selector bits within chain bits 39:3.");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Current ratio in tenths of a percent for a 7-bit group code.
  // Integer division keeps the end points exact: code 0 gives 60 and the top code 1000.
  function automatic logic [RATIO_W-1:0] ratio_permille(input logic [BRIGHT_W-1:0] code);
    int value;
    value = RATIO_MIN_PERMILLE + (int'(code) * RATIO_SPAN_PERMILLE) / BRIGHT_MAX;
    return value[RATIO_W-1:0];
  endfunction

  // True when the latch word enables no sink at all.
  function automatic logic all_off(input logic [LATCH_W-1:0] bits);
    return bits == ENABLE_RESET;
  endfunction

  // Power-save selector as it sits in a function store word.
  function automatic logic [SELECTOR_W-1:0] selector_of(input logic [STORE_W-1:0] word);
    return word[SELECTOR_POS +: SELECTOR_W];
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // The link chain keeps the raw reset: its clock runs only inside frames,
  // so a synchroniser there would swallow the first shift edges.
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Link-side shift chain
  // ----------------------------------------------------------------
  logic [CHAIN_W-1:0] link_chain;
  logic link_toggle;

  // The chain hands its word and a toggle of every shift edge to this domain.
  lslc_shift_chain u_chain (
    .shift_clk(SHIFT_CLK),
    .arst_n(ARST_N),
    .serial_data_in(SERIAL_DATA_IN),
    .serial_data_out(SERIAL_DATA_OUT),
    .chain(link_chain),
    .shift_toggle(link_toggle)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Synchroniser stages come first; the rest is the device state proper.
  typedef struct packed {
    logic [CHAIN_W-1:0] chain_meta;
    logic [CHAIN_W-1:0] chain_sync;
    logic toggle_meta;
    logic toggle_sync;
    logic toggle_prev;
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic blank_meta;
    logic blank_sync;
    logic [LATCH_W-1:0] enable_latch;
    logic [STORE_W-1:0] store;
    logic [PEAK_W-1:0] peak_pending;
    logic peak_pending_valid;
    lslc_power_type power;
    logic [LATCH_W-1:0] sink;
    logic [RATIO_W-1:0] red_ratio;
    logic [RATIO_W-1:0] green_ratio;
    logic [RATIO_W-1:0] blue_ratio;
  } lslc_state_type;

  localparam lslc_state_type STATE_RESET = '{
    chain_meta: CHAIN_RESET,
    chain_sync: CHAIN_RESET,
    toggle_meta: 1'b0,
    toggle_sync: 1'b0,
    toggle_prev: 1'b0,
    strobe_meta: 1'b0,
    strobe_sync: 1'b0,
    strobe_prev: 1'b0,
    // Blanking starts high so the sinks stay off until the pin is sampled.
    blank_meta: 1'b1,
    blank_sync: 1'b1,
    enable_latch: ENABLE_RESET,
    store: STORE_RESET,
    peak_pending: PEAK_RESET,
    peak_pending_valid: 1'b0,
    power: LSLC_NORMAL,
    sink: ENABLE_RESET,
    // A zero code still selects the lowest step, so the ratios start at the floor.
    red_ratio: RATIO_W'(RATIO_MIN_PERMILLE),
    green_ratio: RATIO_W'(RATIO_MIN_PERMILLE),
    blue_ratio: RATIO_W'(RATIO_MIN_PERMILLE)
  };

  lslc_state_type state;
  lslc_state_type next_state;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic strobe_rise;
  logic shift_event;
  logic enable_write;
  logic function_write;
  logic [SELECTOR_W-1:0] selector;
  logic [LATCH_W-1:0] enable_now;
  logic [BRIGHT_W-1:0] red_now;
  logic [BRIGHT_W-1:0] green_now;
  logic [BRIGHT_W-1:0] blue_now;

  always_comb begin
    next_state = state;

    // The chain word is crossed as a quasi-static bus: it is only used on a
    // strobe edge that went through the same two-stage delay, while the
    // controller holds the chain still.
    next_state.chain_meta = link_chain;
    next_state.chain_sync = state.chain_meta;
    next_state.toggle_meta = link_toggle;
    next_state.toggle_sync = state.toggle_meta;
    next_state.toggle_prev = state.toggle_sync;
    next_state.strobe_meta = LATCH_STROBE;
    next_state.strobe_sync = state.strobe_meta;
    next_state.strobe_prev = state.strobe_sync;
    next_state.blank_meta = BLANKING;
    next_state.blank_sync = state.blank_meta;

    // A strobe edge is taken one cycle after its synchronised copy rises; the
    // chain word crossed through the same two stages and is settled by then.
    strobe_rise = state.strobe_sync & ~state.strobe_prev;
    // Each shift edge flips the crossed toggle, so any change of its
    // synchronised copy marks at least one edge on the link.
    shift_event = state.toggle_sync ^ state.toggle_prev; // see [R9]

    // Top bit selects the destination of a strobe.
    // A set top bit with any other command byte is ignored, pending copy included.
    enable_write = strobe_rise & ~state.chain_sync[SELECT_BIT]; // see [R14]
    function_write = strobe_rise & state.chain_sync[SELECT_BIT] // see [R17]
      & (state.chain_sync[CMD_HI:CMD_LO] == WRITE_CMD); // see [R15] [R21]

    if (enable_write) begin
      next_state.enable_latch = state.chain_sync[LATCH_W-1:0]; // see [R14] [R13]
    end

    if (function_write) begin
      next_state.store[FUNC_HI:FUNC_LO] = state.chain_sync[FUNC_HI:FUNC_LO]; // see [R15]
      // Peak code moves only when the same value arrives twice in a row.
      // The first write of a new code only arms the pending copy.
      if (state.peak_pending_valid && state.peak_pending == state.chain_sync[PEAK_HI:PEAK_LO]) begin
        next_state.store[PEAK_HI:PEAK_LO] = state.chain_sync[PEAK_HI:PEAK_LO]; // see [R16]
      end
      next_state.peak_pending = state.chain_sync[PEAK_HI:PEAK_LO]; // see [R16]
      next_state.peak_pending_valid = 1'b1;
    end

    // Power-save control uses the selector as it stands after this write.
    // With selector 01 a zero write and a shift edge in one cycle leave the
    // device in power save, since the write is the later request of the two.
    selector = selector_of(next_state.store); // see [R22]
    enable_now = next_state.enable_latch;
    case (selector)
      SEL_ALWAYS_ON: begin
        next_state.power = LSLC_NORMAL; // see [R7]
      end
      SEL_ALWAYS_SAVE: begin
        next_state.power = LSLC_SAVE; // see [R7]
      end
      SEL_SCLK_WAKE: begin
        if (enable_write && all_off(enable_now)) begin
          next_state.power = LSLC_SAVE; // see [R8]
        end else if (shift_event) begin
          next_state.power = LSLC_NORMAL; // see [R9]
        end
      end
      default: begin
        if (!all_off(enable_now)) begin
          next_state.power = LSLC_NORMAL; // see [R10]
        end else if (enable_write) begin
          next_state.power = LSLC_SAVE; // see [R8]
        end
      end
    endcase

    // Outputs follow the latch while blanking is low, and are off under blanking or in power save.
    if (next_state.power == LSLC_SAVE || state.blank_sync) begin
      next_state.sink = ENABLE_RESET; // see [R4] [R6]
    end else begin
      next_state.sink = enable_now; // see [R3] [R11]
    end

    // Ratios are registered from the store as it stands after this write,
    // so a new code and its ratio appear on the same edge.
    red_now = next_state.store[RED_HI:RED_LO]; // see [R19]
    green_now = next_state.store[GREEN_HI:GREEN_LO];
    blue_now = next_state.store[BLUE_HI:BLUE_LO];
    next_state.red_ratio = ratio_permille(red_now); // see [R1] [R2]
    next_state.green_ratio = ratio_permille(green_now); // see [R1] [R2]
    next_state.blue_ratio = ratio_permille(blue_now); // see [R1] [R2]
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= STATE_RESET; // see [R5] [R20]
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes from a register, so none glitches while a strobe is decoded.
  assign SINK_OUTPUT = state.sink;
  assign PEAK_CURRENT_CODE = state.store[PEAK_HI:PEAK_LO]; // see [R19]
  assign RED_BRIGHTNESS_CODE = state.store[RED_HI:RED_LO];
  assign GREEN_BRIGHTNESS_CODE = state.store[GREEN_HI:GREEN_LO];
  assign BLUE_BRIGHTNESS_CODE = state.store[BLUE_HI:BLUE_LO];
  assign RED_RATIO_PERMILLE = state.red_ratio;
  assign GREEN_RATIO_PERMILLE = state.green_ratio;
  assign BLUE_RATIO_PERMILLE = state.blue_ratio;
  assign POWER_SAVE_STATE = (state.power == LSLC_SAVE);
  assign ANALOG_ENABLE = (state.power == LSLC_NORMAL); // see [R6]
  assign FAULT_DETECT_ENABLE = (state.power == LSLC_NORMAL); // see [R6]
  assign POWER_SAVE_SELECTOR = selector_of(state.store);

endmodule // lslc_top
`default_nettype wire

// [src/lslc_dummy_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/lslc_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lslc_top_monitor
  import lslc_pkg::*;
#(
  parameter int SELECTOR_POS = DEFAULT_SELECTOR_POS
) (
  // Clocks and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SHIFT_CLK,
  // Link pins
  input wire logic SERIAL_DATA_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic LATCH_STROBE,
  input wire logic BLANKING,
  // Driver outputs
  input wire logic [LATCH_W-1:0] SINK_OUTPUT,
  input wire logic [PEAK_W-1:0] PEAK_CURRENT_CODE,
  input wire logic [BRIGHT_W-1:0] RED_BRIGHTNESS_CODE,
  input wire logic [BRIGHT_W-1:0] GREEN_BRIGHTNESS_CODE,
  input wire logic [BRIGHT_W-1:0] BLUE_BRIGHTNESS_CODE,
  input wire logic [RATIO_W-1:0] RED_RATIO_PERMILLE,
  input wire logic POWER_SAVE_STATE,
  input wire logic ANALOG_ENABLE,
  input wire logic FAULT_DETECT_ENABLE,
  input wire logic [SELECTOR_W-1:0] POWER_SAVE_SELECTOR
);
  // --------------------------------------------------------------
  // Warm-up counters keep checks quiet while the reset sync drains and the chain fills.
  // --------------------------------------------------------------
  logic [2:0] up_cnt;
  logic [5:0] sh_cnt;
  logic live;
  assign live = ARST_N && up_cnt == 3'h7;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  always_ff @(posedge SHIFT_CLK or negedge ARST_N) begin
    if (!ARST_N) sh_cnt <= 6'h0;
    else if (sh_cnt != 6'h31) sh_cnt <= sh_cnt + 6'h1;
  end

  a_blank_off: assert property (@(posedge CLK) disable iff (!live) BLANKING [*5] |-> SINK_OUTPUT == '0)
    else $error("sinks on while blanked");
  a_save_off: assert property (@(posedge CLK) disable iff (!live) POWER_SAVE_STATE |-> SINK_OUTPUT == '0)
    else $error("sinks on in power save");
  a_analog_gate: assert property (@(posedge CLK) disable iff (!live)
    ANALOG_ENABLE == !POWER_SAVE_STATE && FAULT_DETECT_ENABLE == ANALOG_ENABLE)
    else $error("analog enables disagree with power state");
  a_always_save: assert property (@(posedge CLK) disable iff (!live)
    POWER_SAVE_SELECTOR == SEL_ALWAYS_SAVE |-> POWER_SAVE_STATE)
    else $error("selector 3 but not saving");
  a_always_on: assert property (@(posedge CLK) disable iff (!live)
    POWER_SAVE_SELECTOR == SEL_ALWAYS_ON |-> !POWER_SAVE_STATE)
    else $error("selector 0 but saving");
  a_ratio_scale: assert property (@(posedge CLK) disable iff (!live)
    RED_RATIO_PERMILLE == RATIO_MIN_PERMILLE + RED_BRIGHTNESS_CODE * RATIO_SPAN_PERMILLE / BRIGHT_MAX)
    else $error("red ratio wrong");
  a_codes_strobe: assert property (@(posedge CLK) disable iff (!live)
    $changed({PEAK_CURRENT_CODE, RED_BRIGHTNESS_CODE, GREEN_BRIGHTNESS_CODE, BLUE_BRIGHTNESS_CODE})
    |-> $past(LATCH_STROBE, 2))
    else $error("codes changed without strobe");
  a_shift_out: assert property (@(posedge SHIFT_CLK) disable iff (!ARST_N)
    sh_cnt == 6'h31 |-> SERIAL_DATA_OUT == $past(SERIAL_DATA_IN, 49))
    else $error("serial out not input delayed by 49");

  cover property (@(posedge CLK) disable iff (!live) $rose(POWER_SAVE_STATE));
  cover property (@(posedge CLK) disable iff (!live) $changed(PEAK_CURRENT_CODE));
  cover property (@(posedge CLK) disable iff (!live) $fell(BLANKING));
endmodule // lslc_top_monitor

bind lslc_top lslc_top_monitor #(.SELECTOR_POS(SELECTOR_POS)) mon (
  .CLK(CLK), .ARST_N(ARST_N), .SHIFT_CLK(SHIFT_CLK), .SERIAL_DATA_IN(SERIAL_DATA_IN),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .LATCH_STROBE(LATCH_STROBE), .BLANKING(BLANKING),
  .SINK_OUTPUT(SINK_OUTPUT), .PEAK_CURRENT_CODE(PEAK_CURRENT_CODE),
  .RED_BRIGHTNESS_CODE(RED_BRIGHTNESS_CODE), .GREEN_BRIGHTNESS_CODE(GREEN_BRIGHTNESS_CODE),
  .BLUE_BRIGHTNESS_CODE(BLUE_BRIGHTNESS_CODE), .RED_RATIO_PERMILLE(RED_RATIO_PERMILLE),
  .POWER_SAVE_STATE(POWER_SAVE_STATE), .ANALOG_ENABLE(ANALOG_ENABLE),
  .FAULT_DETECT_ENABLE(FAULT_DETECT_ENABLE), .POWER_SAVE_SELECTOR(POWER_SAVE_SELECTOR));
`default_nettype wire

// [bench/lslc_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lslc_ctl_model (
  // System clock that paces the strobe
  input wire logic clk,
  // Link towards the driver
  output logic shift_clk,
  output logic serial_data_in,
  output logic latch_strobe,
  output logic blanking
);
  initial begin
    shift_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
    blanking = 1'b1;
  end
  // --------------------------------------------------------------
  // Word transfer: MSB first, the link clock runs only in frames.
  // --------------------------------------------------------------
  task automatic send(input logic [48:0] w);
    @(negedge clk);
    #1.7;
    for (int i = 48; i >= 0; i--) begin
      serial_data_in = w[i];
      #6 shift_clk = 1'b1;
      #6 shift_clk = 1'b0;
    end
    serial_data_in = ~w[0];
    repeat (4) @(negedge clk);
    latch_strobe = 1'b1;
    repeat (6) @(negedge clk);
    latch_strobe = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse();
    @(negedge clk);
    #1.7 shift_clk = 1'b1;
    #6 shift_clk = 1'b0;
  endtask
  task automatic blank(input logic b);
    @(negedge clk);
    blanking = b;
    repeat (6) @(negedge clk);
  endtask
endmodule // lslc_ctl_model
`default_nettype wire

// [bench/led_sink_latch_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module led_sink_latch_control_tb;
  import lslc_pkg::*;
  localparam logic [47:0] PAT = 48'hA5C30F1E7781;
  logic clk;
  logic arst_n;
  wire logic sclk, sdi, stb, blk;
  logic sdo, pss, ana, flt;
  logic [47:0] sink;
  logic [2:0] peak;
  logic [6:0] rc, gc, bc;
  logic [9:0] rr, gr, br;
  logic [1:0] sel;
  int failures = 0;
  int num_checks = 0;

  lslc_ctl_model ctl (.clk(clk), .shift_clk(sclk), .serial_data_in(sdi), .latch_strobe(stb), .blanking(blk));
  lslc_top uut (.CLK(clk), .ARST_N(arst_n), .SHIFT_CLK(sclk), .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .LATCH_STROBE(stb), .BLANKING(blk), .SINK_OUTPUT(sink), .PEAK_CURRENT_CODE(peak),
    .RED_BRIGHTNESS_CODE(rc), .GREEN_BRIGHTNESS_CODE(gc), .BLUE_BRIGHTNESS_CODE(bc),
    .RED_RATIO_PERMILLE(rr), .GREEN_RATIO_PERMILLE(gr), .BLUE_RATIO_PERMILLE(br),
    .POWER_SAVE_STATE(pss), .ANALOG_ENABLE(ana), .FAULT_DETECT_ENABLE(flt), .POWER_SAVE_SELECTOR(sel));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [48:0] fw(input logic [2:0] pk, input logic [6:0] c, input logic [1:0] s);
    logic [48:0] w;
    w = '0;
    w[SELECT_BIT] = 1'b1;
    w[CMD_HI:CMD_LO] = WRITE_CMD;
    w[PEAK_HI:PEAK_LO] = pk;
    w[RED_HI:RED_LO] = c;
    w[GREEN_HI:GREEN_LO] = ~c;
    w[BLUE_HI:BLUE_LO] = c ^ 7'h55;
    w[DEFAULT_SELECTOR_POS +: 2] = s;
    return w;
  endfunction
  function automatic logic [9:0] rt(input logic [6:0] c);
    return 10'(60 + c * 940 / 127);
  endfunction
  task automatic codes(input logic [6:0] c);
    chk("red", rc, c);
    chk("green", gc, c ^ 7'h7F);
    chk("blue", bc, c ^ 7'h55);
    chk("red ratio", rr, rt(c));
    chk("green ratio", gr, rt(~c));
    chk("blue ratio", br, rt(c ^ 7'h55));
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk("sinks", sink, 0);
    chk("peak", peak, 0);
    chk("red ratio", rr, 60);
    chk("save", pss, 0);
    $display("reset test done");
  endtask
  task automatic t_onoff();
    ctl.blank(1'b0);
    ctl.send({1'b0, PAT});
    chk("sinks", sink, PAT);
    chk("red", rc, 0);
    chk("serial out", sdo, 0);
    ctl.blank(1'b1);
    chk("sinks", sink, 0);
    ctl.blank(1'b0);
    chk("sinks", sink, PAT);
    $display("on off test done");
  endtask
  task automatic t_func();
    ctl.send(fw(3'h5, 7'h7F, SEL_ALWAYS_ON));
    codes(7'h7F);
    chk("peak", peak, 0);
    chk("sinks", sink, PAT);
    chk("serial out", sdo, 1);
    ctl.send(fw(3'h5, 7'h40, SEL_ALWAYS_ON));
    codes(7'h40);
    chk("peak", peak, 5);
    $display("function test done");
  endtask
  task automatic t_badcmd();
    logic [48:0] w;
    w = fw(3'h2, 7'h03, SEL_ALWAYS_SAVE);
    w[CMD_HI:CMD_LO] = 8'h95;
    ctl.send(w);
    codes(7'h40);
    chk("peak", peak, 5);
    chk("sinks", sink, PAT);
    $display("bad command test done");
  endtask
  task automatic t_save();
    ctl.send(fw(3'h5, 7'h40, SEL_ALWAYS_SAVE));
    chk("save", {pss, ana, flt, |sink}, 4'h8);
    chk("selector", sel, SEL_ALWAYS_SAVE);
    ctl.send({1'b0, ~PAT});
    ctl.send(fw(3'h5, 7'h40, SEL_ALWAYS_ON));
    chk("save", pss, 0);
    chk("sinks", sink, {~PAT});
    ctl.send(fw(3'h5, 7'h40, SEL_DATA_WAKE));
    ctl.send(49'h0);
    chk("save", pss, 1);
    ctl.send({1'b0, PAT});
    chk("save", pss, 0);
    chk("sinks", sink, PAT);
    ctl.send(fw(3'h5, 7'h40, SEL_SCLK_WAKE));
    ctl.send(49'h0);
    chk("save", pss, 1);
    ctl.blank(1'b1);
    ctl.pulse();
    repeat (8) @(negedge clk);
    chk("save", {pss, ana}, 2'h1);
    ctl.send({1'b0, PAT});
    chk("sinks", sink, 0);
    ctl.blank(1'b0);
    chk("sinks", sink, PAT);
    $display("power save test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_onoff();
    t_func();
    t_badcmd();
    t_save();
    conclude();
  end
endmodule // led_sink_latch_control_tb
`default_nettype wire
